// file: hw/lcf_limit_regs.sv
// Limit registers, limit comparison, fan startup and PWM configuration registers.
`timescale 1ns/1ns
// Contract
// - High limit flags only strictly greater values.
// - Voltage low flags at or below limit.
// - Limit registers writable regardless of lock.
// - Temperature beyond limit sets its status.
// - Fan count above minimum sets fault.
// - Four 16-bit fan minimums, reset all ones.
// - Single-channel mode: fan1 high bits select channel.
// - Single-channel mode: fan1 high low bits reserved.
// - Lock makes PWM configuration registers read-only.
// - Bits 2..0 select startup timeout.
// - Hold PWM high until two tach edges.
// - Timeout without tach: reading all ones, fault.
// - No fault when minimum all ones/zeros.
// - Temperature lows reset one, highs all ones.
// - Status clears on read only if gone.
// - No fan fault while its PWM off.
module lcf_limit_regs #(
	parameter int unsigned SPIN_CYC_1 = lcf_pkg::lcf_ms_to_cyc(lcf_pkg::SPIN_MS_1),
	parameter int unsigned SPIN_CYC_2 = lcf_pkg::lcf_ms_to_cyc(lcf_pkg::SPIN_MS_2),
	parameter int unsigned SPIN_CYC_3 = lcf_pkg::lcf_ms_to_cyc(lcf_pkg::SPIN_MS_3),
	parameter int unsigned SPIN_CYC_4 = lcf_pkg::lcf_ms_to_cyc(lcf_pkg::SPIN_MS_4),
	parameter int unsigned SPIN_CYC_5 = lcf_pkg::lcf_ms_to_cyc(lcf_pkg::SPIN_MS_5),
	parameter int unsigned SPIN_CYC_6 = lcf_pkg::lcf_ms_to_cyc(lcf_pkg::SPIN_MS_6),
	parameter int unsigned SPIN_CYC_7 = lcf_pkg::lcf_ms_to_cyc(lcf_pkg::SPIN_MS_7)
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	input wire logic cfg_lock_i,
	input wire logic single_channel_adc_mode_i,
	input wire logic status1_read_i,
	input wire logic status2_read_i,
	input wire logic [1:0][7:0] volt_value_i,
	input wire logic [1:0] volt_update_i,
	input wire logic [2:0][7:0] temp_value_i,
	input wire logic [2:0] temp_update_i,
	input wire logic [3:0][15:0] fan_count_i,
	input wire logic [3:0] fan_count_update_i,
	input wire logic fan1_speed_input_i,
	input wire logic fan2_speed_input_i,
	input wire logic fan3_speed_input_i,
	input wire logic [2:0] pwm_on_i,
	output logic [2:0] pwm_spin_high_o,
	output logic [3:0][15:0] fan_speed_o,
	output logic [1:0] volt_status_o,
	output logic [2:0] temp_status_o,
	output logic [3:0] fan_status_o,
	output logic [2:0] single_channel_adc_select_o,
	output logic [2:0][7:0] drive_config_o
);
	localparam int TW = lcf_pkg::SPIN_TMR_W;

	typedef struct packed {
		logic [lcf_pkg::NREG-1:0][7:0] regs;
		logic [7:0] rdata;
		logic [1:0] volt_cond;
		logic [1:0] volt_st;
		logic [2:0] temp_cond;
		logic [2:0] temp_st;
		logic [3:0] fan_cond;
		logic [3:0] fan_st;
		logic [3:0][15:0] fan_speed;
		logic [2:0] tach_prev;
		logic [2:0] pwm_prev;
		lcf_pkg::lcf_spin_t [2:0] spin;
		logic [2:0] edge_seen;
		logic [2:0][TW-1:0] tmr;
	} lcf_state_t;

	function automatic logic [lcf_pkg::NREG-1:0][7:0] reset_regs();
		logic [lcf_pkg::NREG-1:0][7:0] r;
		r = '0;
		for (int i = 0; i < 2; i++) begin
			r[2 * i] = lcf_pkg::RST_VOLT_LOW;
			r[2 * i + 1] = lcf_pkg::RST_LIMIT_HIGH;
		end
		for (int i = 0; i < 3; i++) begin
			r[lcf_pkg::IDX_TEMP_BASE + 2 * i] = lcf_pkg::RST_TEMP_LOW;
			r[lcf_pkg::IDX_TEMP_BASE + 2 * i + 1] = lcf_pkg::RST_LIMIT_HIGH;
		end
		for (int i = 0; i < 8; i++) begin
			r[lcf_pkg::IDX_FAN_BASE + i] = lcf_pkg::RST_FAN_MIN;
		end
		for (int i = 0; i < 3; i++) begin
			r[lcf_pkg::IDX_DRIVE_BASE + i] = lcf_pkg::RST_DRIVE;
		end
		return r;
	endfunction : reset_regs

	// Maps a bus address onto the register index; the two mapped ranges leave a gap at 4a..4d.
	function automatic logic [5:0] reg_index(input logic [7:0] a);
		logic [5:0] idx;
		idx = 6'h3f;
		if (a >= lcf_pkg::OFS_PROC_SUPPLY_LOW_LIMIT && a <= lcf_pkg::OFS_MAIN_SUPPLY_HIGH_LIMIT) begin
			idx = 6'(a - lcf_pkg::OFS_PROC_SUPPLY_LOW_LIMIT);
		end else if (a >= lcf_pkg::OFS_REMOTE1_TEMP_LOW_LIMIT && a <= lcf_pkg::OFS_DRIVE3_CONFIG) begin
			idx = 6'(a - lcf_pkg::OFS_REMOTE1_TEMP_LOW_LIMIT + 8'(lcf_pkg::IDX_TEMP_BASE));
		end
		return idx;
	endfunction : reg_index

	function automatic logic [TW-1:0] spin_limit(input logic [2:0] code);
		logic [TW-1:0] lim;
		case (code)
			3'h1: lim = TW'(SPIN_CYC_1);
			3'h2: lim = TW'(SPIN_CYC_2);
			3'h3: lim = TW'(SPIN_CYC_3);
			3'h4: lim = TW'(SPIN_CYC_4);
			3'h5: lim = TW'(SPIN_CYC_5);
			3'h6: lim = TW'(SPIN_CYC_6);
			3'h7: lim = TW'(SPIN_CYC_7);
			default: lim = '0;
		endcase
		return lim;
	endfunction : spin_limit

	lcf_state_t s_reg;
	lcf_state_t s_next;
	logic [2:0] tach_in;

	assign tach_in = {fan3_speed_input_i, fan2_speed_input_i, fan1_speed_input_i};

	always_comb begin
		logic [5:0] idx;
		logic hit;
		logic [7:0] lo;
		logic [7:0] hi;
		logic [15:0] lim;
		logic [15:0] val;
		logic [2:0] code;
		logic [2:0] tmo;
		logic tach_edge;
		logic upd;
		int pw;
		idx = reg_index(reg_addr_i);
		hit = (idx != 6'h3f);
		lo = '0;
		hi = '0;
		lim = '0;
		val = '0;
		code = '0;
		tmo = '0;
		tach_edge = 1'b0;
		upd = 1'b0;
		pw = 0;
		s_next = s_reg;

		if (reg_wr_i && hit) begin
			if (int'(idx) >= lcf_pkg::IDX_DRIVE_BASE) begin
				if (!cfg_lock_i) begin
					s_next.regs[idx] = reg_wdata_i;
				end
			end else if (int'(idx) == lcf_pkg::IDX_FAN1_HI && single_channel_adc_mode_i) begin
				// Only the channel select takes the write; the reserved bits keep the stored limit.
				s_next.regs[idx] = {reg_wdata_i[7:lcf_pkg::ADC_SEL_LSB], s_reg.regs[idx][lcf_pkg::ADC_SEL_LSB-1:0]};
			end else begin
				s_next.regs[idx] = reg_wdata_i;
			end
		end
		if (reg_rd_i) begin
			if (!hit) begin
				s_next.rdata = 8'h00;
			end else if (int'(idx) == lcf_pkg::IDX_FAN1_HI && single_channel_adc_mode_i) begin
				s_next.rdata = {s_reg.regs[idx][7:lcf_pkg::ADC_SEL_LSB], 5'h00};
			end else begin
				s_next.rdata = s_reg.regs[idx];
			end
		end

		for (int i = 0; i < 2; i++) begin
			lo = s_reg.regs[2 * i];
			hi = s_reg.regs[2 * i + 1];
			if (volt_update_i[i]) begin
				s_next.volt_cond[i] = (volt_value_i[i] > hi) || (volt_value_i[i] <= lo);
			end
			// A fresh violation wins over a simultaneous read clear.
			s_next.volt_st[i] = (volt_update_i[i] && s_next.volt_cond[i]) ||
				(s_reg.volt_st[i] && !(status1_read_i && !s_next.volt_cond[i]));
		end

		for (int i = 0; i < 3; i++) begin
			lo = s_reg.regs[lcf_pkg::IDX_TEMP_BASE + 2 * i];
			hi = s_reg.regs[lcf_pkg::IDX_TEMP_BASE + 2 * i + 1];
			if (temp_update_i[i]) begin
				s_next.temp_cond[i] = (temp_value_i[i] > hi) || (temp_value_i[i] < lo);
			end
			s_next.temp_st[i] = (temp_update_i[i] && s_next.temp_cond[i]) ||
				(s_reg.temp_st[i] && !(status1_read_i && !s_next.temp_cond[i]));
		end

		for (int c = 0; c < 3; c++) begin
			code = s_reg.regs[lcf_pkg::IDX_DRIVE_BASE + c][lcf_pkg::SPIN_LSB +: lcf_pkg::SPIN_W];
			tach_edge = tach_in[c] && !s_reg.tach_prev[c];
			case (s_reg.spin[c])
				lcf_pkg::SP_IDLE: begin
					if (pwm_on_i[c] && !s_reg.pwm_prev[c]) begin
						s_next.spin[c] = lcf_pkg::SP_SPIN;
						s_next.edge_seen[c] = 1'b0;
						s_next.tmr[c] = '0;
					end
				end
				lcf_pkg::SP_SPIN: begin
					if (!pwm_on_i[c]) begin
						s_next.spin[c] = lcf_pkg::SP_IDLE;
					end else if (tach_edge) begin
						if (s_reg.edge_seen[c]) begin
							s_next.spin[c] = lcf_pkg::SP_RUN;
						end else begin
							s_next.edge_seen[c] = 1'b1;
						end
					end else if (code != 3'h0 && s_reg.tmr[c] >= spin_limit(code) - 1'b1) begin
						tmo[c] = 1'b1;
						s_next.spin[c] = lcf_pkg::SP_RUN;
					end else begin
						s_next.tmr[c] = TW'(s_reg.tmr[c] + 1'b1);
					end
				end
				lcf_pkg::SP_RUN: begin
					if (!pwm_on_i[c]) begin
						s_next.spin[c] = lcf_pkg::SP_IDLE;
					end
				end
				default: begin
					s_next.spin[c] = lcf_pkg::SP_IDLE;
				end
			endcase
		end
		s_next.tach_prev = tach_in;
		s_next.pwm_prev = pwm_on_i;

		for (int f = 0; f < 4; f++) begin
			pw = (f == 3) ? 2 : f;
			lim = {s_reg.regs[lcf_pkg::IDX_FAN_BASE + 2 * f + 1], s_reg.regs[lcf_pkg::IDX_FAN_BASE + 2 * f]};
			upd = fan_count_update_i[f];
			val = fan_count_i[f];
			if (f < 3 && tmo[f]) begin
				upd = 1'b1;
				val = lcf_pkg::FAN_ALL_ONES;
			end
			if (upd) begin
				s_next.fan_speed[f] = val;
				s_next.fan_cond[f] = (val > lim) && (lim != lcf_pkg::FAN_ALL_ONES) &&
					(lim != lcf_pkg::FAN_ALL_ZERO);
			end
			s_next.fan_st[f] = (upd && s_next.fan_cond[f] && pwm_on_i[pw]) ||
				(s_reg.fan_st[f] && !(status2_read_i && !s_next.fan_cond[f]));
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_reg <= '{regs: reset_regs(), fan_speed: {4{lcf_pkg::FAN_ALL_ONES}}, spin: {3{lcf_pkg::SP_IDLE}},
				default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign reg_rdata_o = s_reg.rdata;
	assign volt_status_o = s_reg.volt_st;
	assign temp_status_o = s_reg.temp_st;
	assign fan_status_o = s_reg.fan_st;
	assign fan_speed_o = s_reg.fan_speed;
	assign single_channel_adc_select_o = s_reg.regs[lcf_pkg::IDX_FAN1_HI][7:lcf_pkg::ADC_SEL_LSB];

	for (genvar c = 0; c < 3; c++) begin : g_drive
		assign pwm_spin_high_o[c] = (s_reg.spin[c] == lcf_pkg::SP_SPIN);
		assign drive_config_o[c] = s_reg.regs[lcf_pkg::IDX_DRIVE_BASE + c];
	end
endmodule : lcf_limit_regs

// file: inc/lcf_pkg.sv
// Constants and types shared by the limit compare and fan startup register bank.
package lcf_pkg;
	localparam int NREG = 21;
	localparam logic [7:0] OFS_PROC_SUPPLY_LOW_LIMIT = 8'h46;
	localparam logic [7:0] OFS_PROC_SUPPLY_HIGH_LIMIT = 8'h47;
	localparam logic [7:0] OFS_MAIN_SUPPLY_LOW_LIMIT = 8'h48;
	localparam logic [7:0] OFS_MAIN_SUPPLY_HIGH_LIMIT = 8'h49;
	localparam logic [7:0] OFS_REMOTE1_TEMP_LOW_LIMIT = 8'h4e;
	localparam logic [7:0] OFS_REMOTE1_TEMP_HIGH_LIMIT = 8'h4f;
	localparam logic [7:0] OFS_LOCAL_TEMP_LOW_LIMIT = 8'h50;
	localparam logic [7:0] OFS_LOCAL_TEMP_HIGH_LIMIT = 8'h51;
	localparam logic [7:0] OFS_REMOTE2_TEMP_LOW_LIMIT = 8'h52;
	localparam logic [7:0] OFS_REMOTE2_TEMP_HIGH_LIMIT = 8'h53;
	localparam logic [7:0] OFS_FAN1_SPEED_MIN_LO = 8'h54;
	localparam logic [7:0] OFS_FAN1_SPEED_MIN_HI_ADC_SELECT = 8'h55;
	localparam logic [7:0] OFS_FAN2_SPEED_MIN_LO = 8'h56;
	localparam logic [7:0] OFS_FAN2_SPEED_MIN_HI = 8'h57;
	localparam logic [7:0] OFS_FAN3_SPEED_MIN_LO = 8'h58;
	localparam logic [7:0] OFS_FAN3_SPEED_MIN_HI = 8'h59;
	localparam logic [7:0] OFS_FAN4_SPEED_MIN_LO = 8'h5a;
	localparam logic [7:0] OFS_FAN4_SPEED_MIN_HI = 8'h5b;
	localparam logic [7:0] OFS_DRIVE1_CONFIG = 8'h5c;
	localparam logic [7:0] OFS_DRIVE2_CONFIG = 8'h5d;
	localparam logic [7:0] OFS_DRIVE3_CONFIG = 8'h5e;
	localparam int IDX_TEMP_BASE = 4;
	localparam int IDX_FAN_BASE = 10;
	localparam int IDX_FAN1_HI = 11;
	localparam int IDX_DRIVE_BASE = 18;
	localparam logic [7:0] RST_VOLT_LOW = 8'h00;
	localparam logic [7:0] RST_LIMIT_HIGH = 8'hff;
	localparam logic [7:0] RST_TEMP_LOW = 8'h01;
	localparam logic [7:0] RST_FAN_MIN = 8'hff;
	localparam logic [7:0] RST_DRIVE = 8'h82;
	localparam int SPIN_LSB = 0;
	localparam int SPIN_W = 3;
	localparam int ADC_SEL_LSB = 5;
	localparam logic [15:0] FAN_ALL_ONES = 16'hffff;
	localparam logic [15:0] FAN_ALL_ZERO = 16'h0000;
	localparam int CLK_HZ = 20_000_000;
	localparam int SPIN_MS_1 = 100;
	localparam int SPIN_MS_2 = 250;
	localparam int SPIN_MS_3 = 400;
	localparam int SPIN_MS_4 = 667;
	localparam int SPIN_MS_5 = 1000;
	localparam int SPIN_MS_6 = 2000;
	localparam int SPIN_MS_7 = 4000;
	localparam int SPIN_TMR_W = 27;

	typedef enum logic [1:0] {
		SP_IDLE = 2'b00,
		SP_SPIN = 2'b01,
		SP_RUN = 2'b11
	} lcf_spin_t;

	function automatic int unsigned lcf_ms_to_cyc(input int unsigned ms);
		lcf_ms_to_cyc = ms * (CLK_HZ / 1000);
	endfunction : lcf_ms_to_cyc
endpackage : lcf_pkg

// file: dv/lcf_fan_model.sv
// Tachometer model of a fan that starts turning once its drive is on.
`timescale 1ns/1ns
module lcf_fan_model #(
	parameter int HALF = 4
) (
	input wire logic clk_i,
	input wire logic run_i,
	output logic tach_o
);
	int cnt = 0;
	initial tach_o = 1'b0;
	always @(posedge clk_i) begin
		if (!run_i) begin
			cnt <= 0;
			tach_o <= 1'b0;
		end else if (cnt == HALF - 1) begin
			cnt <= 0;
			tach_o <= !tach_o;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule : lcf_fan_model

// file: dv/lcf_limit_regs_asserts.sv
// Assertions on the ports of the limit register bank.
`timescale 1ns/1ns
module lcf_limit_regs_asserts (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic cfg_lock_i,
	input wire logic status1_read_i,
	input wire logic [1:0] volt_update_i,
	input wire logic [2:0] temp_update_i,
	input wire logic [2:0] pwm_on_i,
	input wire logic [2:0] pwm_spin_high_o,
	input wire logic [1:0] volt_status_o,
	input wire logic [2:0] temp_status_o,
	input wire logic [3:0] fan_status_o,
	input wire logic [2:0] single_channel_adc_select_o,
	input wire logic [2:0][7:0] drive_config_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_spin_start;
		!pwm_on_i[0] ##1 pwm_on_i[0];
	endsequence
	a_spin_raised: assert property (s_spin_start |=> pwm_spin_high_o[0])
		else $error("spin not raised");
	a_spin_off: assert property (!pwm_on_i[0] |=> !pwm_spin_high_o[0])
		else $error("spin while drive off");
	a_fan_gated: assert property ($rose(fan_status_o[0]) |-> $past(pwm_on_i[0]))
		else $error("fan fault with drive off");
	a_volt_cause: assert property ($rose(volt_status_o[0]) |-> $past(volt_update_i[0]))
		else $error("volt status without update");
	a_temp_cause: assert property ($rose(temp_status_o[0]) |-> $past(temp_update_i[0]))
		else $error("temp status without update");
	a_status_sticky: assert property (volt_status_o[0] && !status1_read_i |=> volt_status_o[0])
		else $error("status cleared without read");
	a_lock_holds: assert property (cfg_lock_i |=> $stable(drive_config_o))
		else $error("locked config changed");
	a_sel_by_write: assert property ($changed(single_channel_adc_select_o)
		|-> $past(reg_wr_i && reg_addr_i == 8'h55))
		else $error("channel select changed alone");
endmodule : lcf_limit_regs_asserts
bind lcf_limit_regs lcf_limit_regs_asserts u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
	.reg_wr_i(reg_wr_i), .cfg_lock_i(cfg_lock_i), .status1_read_i(status1_read_i), .volt_update_i(volt_update_i),
	.temp_update_i(temp_update_i), .pwm_on_i(pwm_on_i), .pwm_spin_high_o(pwm_spin_high_o),
	.volt_status_o(volt_status_o), .temp_status_o(temp_status_o), .fan_status_o(fan_status_o),
	.single_channel_adc_select_o(single_channel_adc_select_o), .drive_config_o(drive_config_o));

// file: dv/lcf_limit_regs_tb.sv
// Self-checking testbench of the limit register bank.
`timescale 1ns/1ns
module lcf_limit_regs_tb;
	logic clk = 0, rst_n = 0, wr = 0, rd = 0, lock = 0, mode = 0, s1 = 0, s2 = 0, fan1_speed_input, fan2_speed_input, fan3_speed_input;
	// A fan only turns when its drive is on and it is marked healthy here; a dead fan exercises the timeout.
	logic [2:0] fan_ok = 3'h1;
	logic [7:0] addr = '0, wdata = '0, rdata;
	logic [1:0][7:0] vval = '0;
	logic [1:0] vupd = '0, vst;
	logic [2:0][7:0] tval = '0, dcfg;
	logic [2:0] tupd = '0, pwm = '0, spin, tst, sel;
	logic [3:0][15:0] fcnt = '0, fspd;
	logic [3:0] fupd = '0, fst;
	int n_errors = 0, cmp_count = 0, n, e;
	always #25 clk = !clk;
	lcf_fan_model fan1 (.clk_i(clk), .run_i(pwm[0] && fan_ok[0]), .tach_o(fan1_speed_input));
	lcf_fan_model fan2 (.clk_i(clk), .run_i(pwm[1] && fan_ok[1]), .tach_o(fan2_speed_input));
	lcf_fan_model fan3 (.clk_i(clk), .run_i(pwm[2] && fan_ok[2]), .tach_o(fan3_speed_input));
	lcf_limit_regs #(.SPIN_CYC_1(20), .SPIN_CYC_2(40)) uut (.clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
		.reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .cfg_lock_i(lock),
		.single_channel_adc_mode_i(mode), .status1_read_i(s1), .status2_read_i(s2), .volt_value_i(vval),
		.volt_update_i(vupd), .temp_value_i(tval), .temp_update_i(tupd), .fan_count_i(fcnt),
		.fan_count_update_i(fupd), .fan1_speed_input_i(fan1_speed_input), .fan2_speed_input_i(fan2_speed_input),
		.fan3_speed_input_i(fan3_speed_input), .pwm_on_i(pwm), .pwm_spin_high_o(spin), .fan_speed_o(fspd),
		.volt_status_o(vst), .temp_status_o(tst), .fan_status_o(fst), .single_channel_adc_select_o(sel),
		.drive_config_o(dcfg));
	task automatic give_verdict();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wreg
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		chk(16'(rdata), 16'(exp));
	endtask : rchk
	// Kind 0 pulses a voltage update, 1 a temperature update, 2 a fan count update.
	task automatic meas(input int k, input int i, input logic [15:0] v, input logic rdst);
		@(posedge clk);
		vval[i] <= v[7:0];
		tval[i] <= v[7:0];
		fcnt[i] <= v;
		vupd[i] <= (k == 0);
		tupd[i] <= (k == 1);
		fupd[i] <= (k == 2);
		s1 <= rdst;
		@(posedge clk);
		vupd <= '0;
		tupd <= '0;
		fupd <= '0;
		s1 <= 1'b0;
		@(negedge clk);
	endtask : meas
	// Starts one drive channel and counts cycles and fan1 tach edges until its startup drive ends.
	task automatic spin_run(input int ch);
		logic tp;
		tp = 1'b0;
		n = 0;
		e = 0;
		@(posedge clk);
		pwm[ch] <= 1'b1;
		repeat (2) @(negedge clk);
		chk(16'(spin[ch]), 16'h1);
		while (spin[ch] === 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
			e += int'(fan1_speed_input && !tp);
			tp = fan1_speed_input;
		end
		if (n >= 200) begin
			n_errors++;
			give_verdict();
		end
		repeat (2) @(negedge clk);
	endtask : spin_run
	task automatic t_reset();
		for (int a = 8'h46; a <= 8'h5e; a++) begin
			rchk(8'(a), a <= 8'h49 ? (a[0] ? 8'hff : 8'h00) : a <= 8'h4d ? 8'h00 : a <= 8'h53 ?
				(a[0] ? 8'hff : 8'h01) : a <= 8'h5b ? 8'hff : 8'h82);
		end
		chk(16'(dcfg[2]), 16'h82);
		chk(16'(sel), 16'h7);
	endtask : t_reset
	task automatic t_lock();
		@(posedge clk);
		lock <= 1'b1;
		wreg(8'h5c, 8'h00);
		wreg(8'h46, 8'h20);
		rchk(8'h5c, 8'h82);
		rchk(8'h46, 8'h20);
		@(posedge clk);
		lock <= 1'b0;
	endtask : t_lock
	task automatic t_limits();
		wreg(8'h47, 8'h80);
		meas(0, 0, 16'h80, 1'b0);
		chk(16'(vst[0]), 16'h0);
		meas(0, 0, 16'h81, 1'b0);
		chk(16'(vst[0]), 16'h1);
		meas(0, 0, 16'h50, 1'b1);
		chk(16'(vst[0]), 16'h0);
		meas(0, 0, 16'h20, 1'b0);
		chk(16'(vst[0]), 16'h1);
		meas(1, 0, 16'h01, 1'b0);
		chk(16'(tst[0]), 16'h0);
		meas(1, 0, 16'h00, 1'b0);
		chk(16'(tst[0]), 16'h1);
	endtask : t_limits
	task automatic t_fans();
		spin_run(0);
		chk(16'(e), 16'h2);
		wreg(8'h56, 8'h00);
		wreg(8'h57, 8'h01);
		meas(2, 1, 16'h0200, 1'b0);
		chk(16'(fst[1]), 16'h0);
		wreg(8'h5d, 8'h81);
		spin_run(1);
		chk(16'(n >= 12 && n <= 24), 16'h1);
		chk(fspd[1], 16'hffff);
		chk(16'(fst[1]), 16'h1);
		@(posedge clk);
		s2 <= 1'b1;
		@(posedge clk);
		s2 <= 1'b0;
		@(negedge clk);
		chk(16'(fst[1]), 16'h1);
		wreg(8'h58, 8'h00);
		wreg(8'h59, 8'h00);
		spin_run(2);
		chk(16'(n >= 32 && n <= 44), 16'h1);
		chk(16'(fst[2]), 16'h0);
	endtask : t_fans
	task automatic t_adc();
		@(posedge clk);
		mode <= 1'b1;
		wreg(8'h55, 8'hab);
		rchk(8'h55, 8'ha0);
		chk(16'(sel), 16'h5);
		@(posedge clk);
		mode <= 1'b0;
		wreg(8'h55, 8'h3c);
		rchk(8'h55, 8'h3c);
		chk(16'(sel), 16'h1);
	endtask : t_adc
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_lock();
		t_limits();
		t_fans();
		t_adc();
		give_verdict();
	end
endmodule : lcf_limit_regs_tb
